// ### gpc_map.svh
// gpc_map.svh: register offsets, fields, reset values and timing constants
`ifndef GPC_MAP_SVH
`define GPC_MAP_SVH

// ****************************************************************
// register offsets (byte addresses, one word each)
// ****************************************************************
`define GPC_OFF_CFG       8'h00
`define GPC_OFF_CTRL      8'h04
`define GPC_OFF_RSTDATA   8'h08
`define GPC_OFF_FLASH_THR 8'h0c
`define GPC_OFF_SLEEP_CUR 8'h10
`define GPC_OFF_STATUS    8'h14
`define GPC_OFF_INT_STAT  8'h18
`define GPC_OFF_INT_CLR   8'h1c
`define GPC_OFF_INT_EN    8'h20
`define GPC_OFF_OFFSET    8'h24
`define GPC_OFF_FLASH_REQ 8'h28

// ****************************************************************
// fields and reset values
// ****************************************************************
`define GPC_CFG_SEL_LO    0
`define GPC_CFG_SEL_HI    1
`define GPC_CFG_RANGE     2
`define GPC_CFG_SLEEP_EN  3
`define GPC_CTL_RESET     0
`define GPC_CTL_TYPE_LSB  1
`define GPC_CTL_RDATA     3
`define GPC_INT_WAKE      0
`define GPC_INT_CAL_DONE  1
`define GPC_INT_CAL_ABORT 2
`define GPC_INT_FLASH_REF 3
`define GPC_RST_FLASH_THR 16'h0af0
`define GPC_RST_SLEEP_CUR 16'h000a

// ****************************************************************
// thresholds and timing
// ****************************************************************
`define GPC_CAL_TLO       8'sh05
`define GPC_CAL_THI       8'sh2d
`define GPC_TDRIFT_C      8'h08
`define GPC_CAL_IMAX_MA   16'h0064
`define GPC_CAL_DV_MV     16'h0100
`define GPC_ABORT_DV_MV   16'h0020
`define GPC_CLK_MHZ       125
`define GPC_CAL_US        1000
`define GPC_TDRIFT_S      60
`define GPC_WAKE_T1_UV    16'h03e8
`define GPC_WAKE_T2_UV    16'h0898
`define GPC_WAKE_T4_UV    16'h11f8
`define GPC_WAKE_T9_UV    16'h2648

`endif

// ### gpc_pkg.sv
// gpc_pkg.sv: types shared by the power and calibration control block
package gpc_pkg;

  typedef enum logic [1:0] {
    GPC_NORM  = 2'b00,
    GPC_SCAL  = 2'b01,
    GPC_PCAL  = 2'b10,
    GPC_SLEEP = 2'b11
  } gpc_pwr_e;

  typedef struct packed {
    gpc_pwr_e           pwr;
    logic [3:0]         cfg;
    logic [15:0]        flash_thr;
    logic [15:0]        sleep_cur;
    logic [3:0][7:0]    rst_cnt;
    logic [31:0]        rst_snap;
    logic [3:0]         int_stat;
    logic [3:0]         int_en;
    logic               irq;
    logic [31:0]        prdata;
    logic               pready;
    logic               pslverr;
    logic [19:0]        cal_cnt;
    logic [15:0]        cal_v0;
    logic signed [15:0] offset;
    logic [15:0]        last_cal_v;
    logic signed [7:0]  last_cal_t;
    logic [32:0]        tdrift_cnt;
    logic               above;
    logic               wake_ev;
    logic signed [15:0] sense_corr;
    logic signed [15:0] cur_acc;
    logic               flash_wr;
    logic               soft_rst;
    logic [1:0]         soft_rst_type;
  } gpc_state_s;

endpackage

// ### gpc_wake_cmp.sv
// gpc_wake_cmp.sv: wake comparator threshold select and level compare
`timescale 1ns/100ps
`include "gpc_map.svh"
module gpc_wake_cmp
  import gpc_pkg::*;
(
  input  wire logic               sel_hi_i,
  input  wire logic               sel_lo_i,
  input  wire logic               range_i,
  input  wire logic signed [15:0] sense_i,
  output logic                    en_o,
  output logic                    above_o
);

  // threshold in microvolts from select bits and range
  function automatic logic [15:0] thr_uv(input logic [2:0] s);
    case (s)
      3'b010:  thr_uv = `GPC_WAKE_T1_UV;
      3'b011:  thr_uv = `GPC_WAKE_T2_UV;
      3'b100:  thr_uv = `GPC_WAKE_T2_UV;
      3'b101:  thr_uv = `GPC_WAKE_T4_UV;
      3'b110:  thr_uv = `GPC_WAKE_T4_UV;
      3'b111:  thr_uv = `GPC_WAKE_T9_UV;
      default: thr_uv = 16'hffff;
    endcase
  endfunction

  logic [15:0] mag;

  // magnitude covers charge and discharge alike
  always_comb begin
    mag     = sense_i[15] ? 16'(-sense_i) : 16'(sense_i);
    en_o    = sel_hi_i | sel_lo_i;
    above_o = en_o && (mag >= thr_uv({sel_hi_i, sel_lo_i, range_i}));
  end

endmodule // gpc_wake_cmp

// ### gpc_top.sv
// gpc_top.sv: gauge power, reset count, flash gate and calibration control
`timescale 1ns/100ps
`include "gpc_map.svh"
module gpc_top
  import gpc_pkg::*;
#(
  parameter int          CAL_CYC    = `GPC_CAL_US * `GPC_CLK_MHZ,
  parameter logic [32:0] TDRIFT_CYC = 33'(`GPC_TDRIFT_S * 64'd1000000 *
                                          `GPC_CLK_MHZ)
)(
  input  wire logic               sys_clk_i,
  input  wire logic               rst_n_i,
  input  wire logic               psel_i,
  input  wire logic               penable_i,
  input  wire logic               pwrite_i,
  input  wire logic [7:0]         paddr_i,
  input  wire logic [31:0]        pwdata_i,
  output logic [31:0]             prdata_o,
  output logic                    pready_o,
  output logic                    pslverr_o,
  input  wire logic signed [15:0] sense_uv_i,
  input  wire logic [15:0]        volt_mv_i,
  input  wire logic signed [7:0]  temp_c_i,
  input  wire logic signed [15:0] mean_current_reading_i,
  output logic signed [15:0]      sense_corr_o,
  output logic signed [15:0]      cur_acc_o,
  output logic                    cal_busy_o,
  output logic                    sleep_o,
  output logic                    flash_wr_o,
  output logic                    soft_rst_o,
  output logic [1:0]              soft_rst_type_o,
  output logic                    irq_o
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic reg_hit(input logic [7:0] a);
    case (a)
      `GPC_OFF_CFG, `GPC_OFF_CTRL, `GPC_OFF_RSTDATA, `GPC_OFF_FLASH_THR,
      `GPC_OFF_SLEEP_CUR, `GPC_OFF_STATUS, `GPC_OFF_INT_STAT,
      `GPC_OFF_INT_CLR, `GPC_OFF_INT_EN, `GPC_OFF_OFFSET,
      `GPC_OFF_FLASH_REQ: reg_hit = 1'b1;
      default:            reg_hit = 1'b0;
    endcase
  endfunction

  function automatic logic [15:0] absd(input logic [15:0] a,
                                       input logic [15:0] b);
    absd = (a >= b) ? 16'(a - b) : 16'(b - a);
  endfunction

  function automatic logic [15:0] mag16(input logic signed [15:0] v);
    mag16 = v[15] ? 16'(-v) : 16'(v);
  endfunction

  gpc_state_s st_r;
  gpc_state_s st_nxt;
  logic       wk_en;
  logic       wk_above;
  logic       setup;
  logic       wr;
  logic [3:0] ev;
  logic [3:0] clr;
  logic [15:0] cur_mag;
  logic [7:0]  tdiff;
  logic        temp_ok;
  logic        cal_end;
  logic        cal_abort;

  // ****************************************************************
  // wake comparator
  // ****************************************************************
  gpc_wake_cmp u_wake (
    .sel_hi_i (st_r.cfg[`GPC_CFG_SEL_HI]),
    .sel_lo_i (st_r.cfg[`GPC_CFG_SEL_LO]),
    .range_i  (st_r.cfg[`GPC_CFG_RANGE]),
    .sense_i  (sense_uv_i),
    .en_o     (wk_en),
    .above_o  (wk_above)
  );

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    st_nxt    = st_r;
    ev        = 4'h0;
    clr       = 4'h0;
    setup     = psel_i & ~penable_i;
    wr        = psel_i & penable_i & st_r.pready & pwrite_i;
    cur_mag   = mag16(mean_current_reading_i);
    tdiff     = (temp_c_i >= st_r.last_cal_t) ? 8'(temp_c_i - st_r.last_cal_t)
                                              : 8'(st_r.last_cal_t - temp_c_i);
    temp_ok   = (temp_c_i > `GPC_CAL_TLO) && (temp_c_i < `GPC_CAL_THI);
    cal_end   = st_r.cal_cnt == 20'(CAL_CYC - 1);
    cal_abort = (st_r.cal_v0 > volt_mv_i) &&
                (16'(st_r.cal_v0 - volt_mv_i) > `GPC_ABORT_DV_MV);
    st_nxt.soft_rst = 1'b0;
    st_nxt.flash_wr = 1'b0;

    // apb: zero wait states, answer prepared in the setup cycle
    st_nxt.pready  = setup;
    st_nxt.pslverr = setup & ~reg_hit(paddr_i);
    st_nxt.prdata  = 32'h0;
    if (setup && !pwrite_i) begin
      case (paddr_i)
        `GPC_OFF_CFG:       st_nxt.prdata = {28'h0, st_r.cfg};
        `GPC_OFF_RSTDATA:   st_nxt.prdata = st_r.rst_snap;
        `GPC_OFF_FLASH_THR: st_nxt.prdata = {16'h0, st_r.flash_thr};
        `GPC_OFF_SLEEP_CUR: st_nxt.prdata = {16'h0, st_r.sleep_cur};
        `GPC_OFF_STATUS:    st_nxt.prdata = {28'h0, wk_en, st_r.above,
                                             st_r.pwr};
        `GPC_OFF_INT_STAT:  st_nxt.prdata = {28'h0, st_r.int_stat};
        `GPC_OFF_INT_EN:    st_nxt.prdata = {28'h0, st_r.int_en};
        `GPC_OFF_OFFSET:    st_nxt.prdata = {{16{st_r.offset[15]}},
                                             st_r.offset};
        default:            st_nxt.prdata = 32'h0;
      endcase
    end

    // register writes take effect at the completing access edge
    if (wr) begin
      case (paddr_i)
        `GPC_OFF_CFG:       st_nxt.cfg = pwdata_i[3:0];
        `GPC_OFF_FLASH_THR: st_nxt.flash_thr = pwdata_i[15:0];
        `GPC_OFF_SLEEP_CUR: st_nxt.sleep_cur = pwdata_i[15:0];
        `GPC_OFF_INT_CLR:   clr = pwdata_i[3:0];
        `GPC_OFF_INT_EN:    st_nxt.int_en = pwdata_i[3:0];
        `GPC_OFF_CTRL: begin
          if (pwdata_i[`GPC_CTL_RESET]) begin
            // classify the reset and bump its own counter
            st_nxt.soft_rst      = 1'b1;
            st_nxt.soft_rst_type = pwdata_i[`GPC_CTL_TYPE_LSB +: 2];
            st_nxt.rst_cnt[pwdata_i[`GPC_CTL_TYPE_LSB +: 2]] =
              8'(st_r.rst_cnt[pwdata_i[`GPC_CTL_TYPE_LSB +: 2]] + 8'h01);
          end
          if (pwdata_i[`GPC_CTL_RDATA])
            st_nxt.rst_snap = st_r.rst_cnt;
        end
        `GPC_OFF_FLASH_REQ: begin
          // a low cell could brown out the regulator mid-program
          if (volt_mv_i >= st_r.flash_thr)
            st_nxt.flash_wr = 1'b1;
          else
            ev[`GPC_INT_FLASH_REF] = 1'b1;
        end
        default: ;
      endcase
    end

    // wake comparator: new crossing only, only while sleeping
    st_nxt.above   = wk_above;
    st_nxt.wake_ev = (st_r.pwr == GPC_SLEEP) && wk_en &&
                     wk_above && !st_r.above;
    ev[`GPC_INT_WAKE] = st_nxt.wake_ev;

    // lasting temperature drift since the last calibration
    if (tdiff > `GPC_TDRIFT_C) begin
      if (st_r.tdrift_cnt != TDRIFT_CYC)
        st_nxt.tdrift_cnt = 33'(st_r.tdrift_cnt + 33'h1);
    end else begin
      st_nxt.tdrift_cnt = 33'h0;
    end

    // power and calibration sequencing
    case (st_r.pwr)
      GPC_NORM: begin
        st_nxt.cal_cnt = 20'h0;
        st_nxt.cal_v0  = volt_mv_i;
        if (st_r.cfg[`GPC_CFG_SLEEP_EN] && cur_mag < st_r.sleep_cur) begin
          // qualified: calibrate before sleeping unless too cold or hot
          st_nxt.pwr = temp_ok ? GPC_PCAL : GPC_SLEEP;
        end else if (cur_mag <= `GPC_CAL_IMAX_MA &&
                     (absd(volt_mv_i, st_r.last_cal_v) >= `GPC_CAL_DV_MV ||
                      st_r.tdrift_cnt == TDRIFT_CYC)) begin
          st_nxt.pwr = GPC_SCAL;
        end
      end
      GPC_SCAL, GPC_PCAL: begin
        st_nxt.cal_cnt = 20'(st_r.cal_cnt + 20'h1);
        if (cal_abort) begin
          // a falling cell means load came back: offset would be wrong
          st_nxt.pwr = GPC_NORM;
          ev[`GPC_INT_CAL_ABORT] = 1'b1;
        end else if (cal_end) begin
          st_nxt.offset     = sense_uv_i;
          st_nxt.last_cal_v = volt_mv_i;
          st_nxt.last_cal_t = temp_c_i;
          st_nxt.tdrift_cnt = 33'h0;
          st_nxt.pwr = (st_r.pwr == GPC_PCAL) ? GPC_SLEEP : GPC_NORM;
          ev[`GPC_INT_CAL_DONE] = 1'b1;
        end
      end
      GPC_SLEEP: begin
        if (cur_mag > st_r.sleep_cur || st_nxt.wake_ev)
          st_nxt.pwr = GPC_NORM;
      end
      default: st_nxt.pwr = GPC_NORM;
    endcase

    // corrected reading; accumulation frozen while the adc calibrates
    st_nxt.sense_corr = 16'(sense_uv_i - st_r.offset);
    if (st_r.pwr != GPC_SCAL && st_r.pwr != GPC_PCAL)
      st_nxt.cur_acc = mean_current_reading_i;

    // sticky status: a set in the clearing cycle wins
    st_nxt.int_stat = (st_r.int_stat & ~clr) | ev;
    st_nxt.irq      = |(st_nxt.int_stat & st_nxt.int_en);
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      st_r           <= '0;
      st_r.flash_thr <= `GPC_RST_FLASH_THR;
      st_r.sleep_cur <= `GPC_RST_SLEEP_CUR;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata_o        = st_r.prdata;
  assign pready_o        = st_r.pready;
  assign pslverr_o       = st_r.pslverr;
  assign sense_corr_o    = st_r.sense_corr;
  assign cur_acc_o       = st_r.cur_acc;
  assign cal_busy_o      = st_r.pwr == GPC_SCAL || st_r.pwr == GPC_PCAL;
  assign sleep_o         = st_r.pwr == GPC_SLEEP;
  assign flash_wr_o      = st_r.flash_wr;
  assign soft_rst_o      = st_r.soft_rst;
  assign soft_rst_type_o = st_r.soft_rst_type;
  assign irq_o           = st_r.irq;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  logic ctl_wr;
  assign ctl_wr = wr && paddr_i == `GPC_OFF_CTRL;

  sequence s_in_cal;
    st_r.pwr == GPC_SCAL || st_r.pwr == GPC_PCAL;
  endsequence

  sequence s_cal_twice;
    s_in_cal ##1 s_in_cal;
  endsequence

  property p_rst_count;
    ctl_wr && pwdata_i[0] && pwdata_i[2:1] == 2'h1 |=>
      st_r.rst_cnt[1] == 8'($past(st_r.rst_cnt[1]) + 8'h01) && soft_rst_o;
  endproperty
  a_rst_count: assert property (p_rst_count)
    else $error("reset counter did not advance");

  property p_rst_data;
    ctl_wr && pwdata_i[3] && !pwdata_i[0] |=>
      st_r.rst_snap == $past(st_r.rst_cnt);
  endproperty
  a_rst_data: assert property (p_rst_data)
    else $error("reset data not captured");

  property p_wake_off;
    !st_r.cfg[0] && !st_r.cfg[1] |=> !st_r.wake_ev;
  endproperty
  a_wake_off: assert property (p_wake_off)
    else $error("wake event while comparator disabled");

  property p_wake_sleep;
    st_r.wake_ev |-> $past(st_r.pwr) == GPC_SLEEP && st_r.pwr == GPC_NORM
                     && st_r.int_stat[0];
  endproperty
  a_wake_sleep: assert property (p_wake_sleep)
    else $error("wake event outside sleep or no exit");

  property p_flash_gate;
    flash_wr_o |-> $past(volt_mv_i) >= $past(st_r.flash_thr);
  endproperty
  a_flash_gate: assert property (p_flash_gate)
    else $error("flash write below permit voltage");

  property p_cal_temp;
    st_r.pwr == GPC_NORM ##1 st_r.pwr == GPC_PCAL |->
      $past(temp_c_i) > 8'sh05 && $past(temp_c_i) < 8'sh2d;
  endproperty
  a_cal_temp: assert property (p_cal_temp)
    else $error("sleep calibration outside temperature window");

  property p_cal_abort;
    s_in_cal ##0 cal_abort |=> st_r.pwr == GPC_NORM && st_r.int_stat[2];
  endproperty
  a_cal_abort: assert property (p_cal_abort)
    else $error("calibration not aborted on voltage drop");

  property p_offset_sub;
    ##1 1'b1 |-> sense_corr_o ==
      16'($past(sense_uv_i) - $past(st_r.offset));
  endproperty
  a_offset_sub: assert property (p_offset_sub)
    else $error("offset not subtracted");

  property p_acc_hold;
    s_cal_twice |-> $stable(cur_acc_o);
  endproperty
  a_acc_hold: assert property (p_acc_hold)
    else $error("accumulation moved during calibration");

endmodule // gpc_top

// ### gpc_fe_model.sv
// gpc_fe_model.sv: behavioural sense resistor and cell measurement front end
`timescale 1ns/100ps
module gpc_fe_model (
  input  wire logic               clk_i,
  input  wire logic signed [15:0] sense_set_i,
  input  wire logic [15:0]        volt_set_i,
  input  wire logic signed [7:0]  temp_set_i,
  input  wire logic signed [15:0] cur_set_i,
  output logic signed [15:0]      sense_uv_o,
  output logic [15:0]             volt_mv_o,
  output logic signed [7:0]       temp_c_o,
  output logic signed [15:0]      cur_o
);
  // known levels from time zero, before the first conversion lands
  initial begin
    sense_uv_o = 16'h0000;
    volt_mv_o  = 16'h0000;
    temp_c_o   = 8'sh00;
    cur_o      = 16'h0000;
  end

  // conversions land one clock after the analog level moves, so the
  // block never sees a level in the same edge that it was changed
  always @(posedge clk_i) begin
    sense_uv_o <= sense_set_i;
    volt_mv_o  <= volt_set_i;
    temp_c_o   <= temp_set_i;
    cur_o      <= cur_set_i;
  end
endmodule // gpc_fe_model

// ### test_gauge_power_calibration_control.sv
// test_gauge_power_calibration_control.sv: self-checking bench of gpc_top
`timescale 1ns/100ps
`include "gpc_map.svh"
module test_gauge_power_calibration_control;
  logic               clk, rst_n, psel, penable, pwrite, err;
  logic               pready, pslverr, cal_busy, sleep, flash_wr, irq;
  logic [1:0]         soft_rst_type;
  logic [7:0]         paddr;
  logic [31:0]        pwdata, prdata, rd;
  logic signed [15:0] sense_set, cur_set, sense_uv, cur_rd, corr, cur_acc;
  logic [15:0]        volt_set, volt_mv;
  logic signed [7:0]  temp_set, temp_c;
  logic [2:0]         c;
  int                 num_errors, cmp_count, cyc, n_flash, n_cal, k;
  logic [15:0]        thr [6] = '{`GPC_WAKE_T1_UV, `GPC_WAKE_T2_UV,
    `GPC_WAKE_T2_UV, `GPC_WAKE_T4_UV, `GPC_WAKE_T4_UV, `GPC_WAKE_T9_UV};
  localparam logic [15:0] V0 = 16'h0ed8;
  localparam logic [15:0] V1 = 16'h1004;

  gpc_top #(.CAL_CYC(12), .TDRIFT_CYC(33'h14)) u_gpc_top (
    .sys_clk_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .sense_uv_i(sense_uv), .volt_mv_i(volt_mv), .temp_c_i(temp_c),
    .mean_current_reading_i(cur_rd), .sense_corr_o(corr),
    .cur_acc_o(cur_acc), .cal_busy_o(cal_busy), .sleep_o(sleep),
    .flash_wr_o(flash_wr), .soft_rst_o(), .soft_rst_type_o(soft_rst_type),
    .irq_o(irq));

  gpc_fe_model u_gpc_fe_model (
    .clk_i(clk), .sense_set_i(sense_set), .volt_set_i(volt_set),
    .temp_set_i(temp_set), .cur_set_i(cur_set), .sense_uv_o(sense_uv),
    .volt_mv_o(volt_mv), .temp_c_o(temp_c), .cur_o(cur_rd));

  // ****************************************************************
  // helpers
  // ****************************************************************
  task test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask

  // one apb transfer; waits on pready without assuming a latency
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    // pready, prdata and pslverr are taken at the completing rising edge
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    chk("apb wait", 32'h0, 32'(n / 20));
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
    xfer(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask

  // front end levels change right after a rising edge
  task fe(input logic [15:0] s, input logic [15:0] v,
          input logic [7:0] t, input logic [15:0] i);
    @(posedge clk);
    sense_set <= s;
    volt_set  <= v;
    temp_set  <= t;
    cur_set   <= i;
  endtask

  // bounded wait on cal_busy_o (bsy=1) or sleep_o (bsy=0)
  task await(input logic bsy, input logic v, input string nm);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while ((bsy ? cal_busy : sleep) !== v && n < 200);
    chk(nm, 32'(v), 32'(bsy ? cal_busy : sleep));
  endtask

  task settle;
    repeat (3) @(negedge clk);
  endtask

  // ****************************************************************
  // clock, watchdog and pulse counters
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (flash_wr === 1'b1) n_flash <= n_flash + 1;
    if (cal_busy === 1'b1) n_cal <= n_cal + 1;
    if (cyc == 20000) begin
      num_errors++;
      test_done;
    end
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    {sense_set, temp_set} = {16'h0000, 8'sh19};
    {volt_set, cur_set} = {V0, 16'h01f4};
    {num_errors, cmp_count, cyc, n_flash, n_cal} = '0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rdc(`GPC_OFF_FLASH_THR, 32'(`GPC_RST_FLASH_THR), "flash_thr");
    rdc(`GPC_OFF_SLEEP_CUR, 32'(`GPC_RST_SLEEP_CUR), "sleep_cur");
    rdc(8'h3c, 32'h0, "unmapped");
    chk("pslverr", 32'h1, 32'(err));
    for (int t = 0; t < 4; t++) repeat (t + 1) wr(`GPC_OFF_CTRL, 32'(t*2+1));
    wr(`GPC_OFF_CTRL, 32'h8);
    rdc(`GPC_OFF_RSTDATA, 32'h04030201, "rst counters");
    chk("soft_rst_type", 32'h3, 32'(soft_rst_type));
    $display("test reset counters done");
    // a refused flash write raises a maskable interrupt
    wr(`GPC_OFF_INT_EN, 32'h8);
    fe(16'h0, `GPC_RST_FLASH_THR - 16'h1, 8'sh19, 16'h01f4);
    wr(`GPC_OFF_FLASH_REQ, 32'h1);
    rdc(`GPC_OFF_INT_STAT, 32'h8, "int_stat");
    chk("flash pulses", 32'h0, 32'(n_flash));
    chk("irq", 32'h1, 32'(irq));
    wr(`GPC_OFF_INT_EN, 32'h0);
    settle;
    chk("irq masked", 32'h0, 32'(irq));
    wr(`GPC_OFF_INT_EN, 32'h8);
    settle;
    chk("irq", 32'h1, 32'(irq));
    wr(`GPC_OFF_INT_CLR, 32'h8);
    settle;
    chk("irq cleared", 32'h0, 32'(irq));
    fe(16'h0, `GPC_RST_FLASH_THR, 8'sh19, 16'h01f4);
    wr(`GPC_OFF_FLASH_REQ, 32'h1);
    settle;
    chk("flash pulses", 32'h1, 32'(n_flash));
    rdc(`GPC_OFF_INT_STAT, 32'h0, "int_stat");
    $display("test flash gate done");
    // single calibration at low current, accumulation held meanwhile
    fe(16'h007b, V0, 8'sh19, 16'h0032);
    await(1'b1, 1'b1, "cal_busy");
    fe(16'h007b, V0, 8'sh19, 16'h003c);
    settle;
    chk("cur_acc held", 32'(16'h0032), 32'(cur_acc));
    await(1'b1, 1'b0, "cal_busy");
    rdc(`GPC_OFF_INT_STAT, 32'h2, "int_stat");
    rdc(`GPC_OFF_OFFSET, 32'h7b, "offset");
    fe(16'h03e8, V0, 8'sh19, 16'h003c);
    settle;
    chk("sense_corr", 32'(16'h03e8 - 16'h007b), 32'(corr));
    chk("cur_acc", 32'(16'h003c), 32'(cur_acc));
    wr(`GPC_OFF_INT_CLR, 32'hf);
    // a drop of exactly the limit keeps running, one more aborts
    fe(16'h0, V1, 8'sh19, 16'h003c);
    await(1'b1, 1'b1, "cal_busy");
    fe(16'h0, V1 - `GPC_ABORT_DV_MV, 8'sh19, 16'h003c);
    settle;
    chk("cal_busy", 32'h1, 32'(cal_busy));
    fe(16'h0, V1 - `GPC_ABORT_DV_MV - 16'h1, 8'sh19, 16'h01f4);
    await(1'b1, 1'b0, "cal_busy");
    rdc(`GPC_OFF_INT_STAT, 32'h4, "int_stat");
    fe(16'h0, V0, 8'sh19, 16'h01f4);
    wr(`GPC_OFF_INT_CLR, 32'hf);
    $display("test calibration done");
    // sleep entry calibrates first, then sleeps; current wakes it
    wr(`GPC_OFF_CFG, 32'hb);
    fe(16'h0, V0, 8'sh19, 16'h0005);
    await(1'b1, 1'b1, "cal_busy");
    chk("sleep early", 32'h0, 32'(sleep));
    await(1'b0, 1'b1, "sleep_o");
    rdc(`GPC_OFF_STATUS, 32'hb, "status");
    fe(16'h0, V0, 8'sh19, 16'h0032);
    await(1'b0, 1'b0, "sleep_o");
    k = n_cal;
    // every threshold code, just below then at the level, even codes positive, odd codes negative
    for (int i = 0; i < 6; i++) begin
      c = 3'(i + 2);
      wr(`GPC_OFF_INT_CLR, 32'hf);
      wr(`GPC_OFF_CFG, {28'h0, 1'b1, c[0], c[2], c[1]});
      fe(16'h0, V0, `GPC_CAL_TLO, 16'h0005);
      await(1'b0, 1'b1, "sleep_o");
      fe(i % 2 ? 16'h1 - thr[i] : thr[i] - 16'h1, V0, `GPC_CAL_TLO, 16'h5);
      repeat (6) @(negedge clk);
      chk("sleep below thr", 32'h1, 32'(sleep));
      fe(i % 2 ? -thr[i] : thr[i], V0, `GPC_CAL_TLO, 16'h0005);
      await(1'b0, 1'b0, "wake");
      rdc(`GPC_OFF_INT_STAT, 32'h1, "int_stat");
      fe(16'h0, V0, `GPC_CAL_TLO, 16'h01f4);
    end
    // comparator off: no wake, and no calibration at the upper limit
    wr(`GPC_OFF_INT_CLR, 32'hf);
    wr(`GPC_OFF_CFG, 32'hc);
    fe(16'h0, V0, `GPC_CAL_THI, 16'h0005);
    await(1'b0, 1'b1, "sleep_o");
    fe(16'h4e20, V0, `GPC_CAL_THI, 16'h0005);
    repeat (6) @(negedge clk);
    chk("sleep disabled cmp", 32'h1, 32'(sleep));
    chk("cal cycles", 32'(k), 32'(n_cal));
    rdc(`GPC_OFF_INT_STAT, 32'h0, "int_stat");
    // back to the calibration temperature so the drift timer cannot
    // start a single calibration in the checks that follow
    fe(16'h0, V0, 8'sh19, 16'h0032);
    await(1'b0, 1'b0, "sleep_o");
    // comparator above while awake must not raise the wake event
    wr(`GPC_OFF_CFG, 32'h3);
    fe(16'h4e20, V0, 8'sh19, 16'h0005);
    repeat (6) @(negedge clk);
    rdc(`GPC_OFF_INT_STAT, 32'h0, "int_stat");
    rdc(`GPC_OFF_STATUS, 32'hc, "status");
    $display("test wake comparator done");
    test_done;
  end
endmodule // test_gauge_power_calibration_control
